// ### rtl/luf_frame_txrx.sv
// Frame transmit and receive engine of an asynchronous serial channel.
`timescale 1ns/1ps

module luf_frame_txrx
  import luf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [BAUD_W-1:0] baud_divisor,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic char_length_select,
  input wire logic stop_length_select,
  input wire logic [1:0] parity_select,
  input wire logic msb_first,
  input wire logic expansion_bit_enable,
  input wire logic tx_polarity_invert,
  input wire logic rx_polarity_invert,
  input wire logic tx_irq_timing_select,
  input wire logic consistency_check_enable,
  input wire logic consistency_error_clear,
  input wire logic overrun_clear,
  input wire logic tx_data_write,
  input wire logic [DATA_W-1:0] tx_data_reg,
  input wire logic rx_data_read,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic [DATA_W-1:0] rx_data_reg,
  output logic tx_busy_flag,
  output logic rx_busy_flag,
  output logic tx_buf_full,
  output logic overrun_flag,
  output logic parity_error_flag,
  output logic framing_error_flag,
  output logic consistency_error_flag,
  output logic tx_irq,
  output logic rx_done_irq,
  output logic status_irq
);

  // ==========================================================================
  // Shared helpers
  // ==========================================================================
  logic ext_on;
  logic [CNT_W-1:0] nbits;
  logic [BAUD_W-1:0] half_div;
  logic rxs1_r, rxs2_r, rxd_r;
  logic rx_line;

  // Expansion framing needs the 8-bit length and its enable together.
  assign ext_on = char_length_select & expansion_bit_enable;
  // Data bits per frame: 7 or 8 character bits plus an optional expansion bit.
  assign nbits = (char_length_select ? 4'h8 : 4'h7) + {3'h0, ext_on};
  assign half_div = {1'b0, baud_divisor[BAUD_W-1:1]};

  // Reorder a character for MSB-first transfer; expansion bit stays last.
  function automatic logic [DATA_W-1:0] reorder(
    input logic [DATA_W-1:0] d,
    input logic msb,
    input logic len8
  );
    logic [DATA_W-1:0] r;
    r = d;
    if (msb) begin
      for (int i = 0; i < 8; i++) begin
        if (len8) begin
          r[i] = d[7-i];
        end else if (i < 7) begin
          r[i] = d[6-i];
        end
      end
    end
    return r;
  endfunction : reorder

  // Parity bit for the data bits actually present in the frame.
  function automatic logic par_bit(
    input logic [DATA_W-1:0] d,
    input logic [1:0] sel,
    input logic len8,
    input logic ext
  );
    logic x;
    x = ^d[6:0] ^ (len8 & d[7]) ^ (ext & d[8]);
    if (sel == PAR_EVEN) begin
      par_bit = x;
    end else if (sel == PAR_ODD) begin
      par_bit = ~x;
    end else begin
      par_bit = 1'b0;
    end
  endfunction : par_bit

  // Two-stage synchroniser, polarity, and an edge flop held low while off.
  always_ff @(posedge clk) begin
    if (reset) begin
      rxs1_r <= 1'b1;
      rxs2_r <= 1'b1;
      rxd_r <= 1'b1;
    end else begin
      rxs1_r <= serial_in_pin;
      rxs2_r <= rxs1_r;
      rxd_r <= rx_line & rx_enable;
    end
  end
  assign rx_line = rxs2_r ^ rx_polarity_invert;

  // ==========================================================================
  // Transmitter
  // ==========================================================================
  luf_state_type tx_st_r;
  logic [BAUD_W-1:0] tx_cnt_r;
  logic [CNT_W-1:0] tx_bit_r;
  logic [DATA_W-1:0] tx_hold_r, tx_sh_r;
  logic tx_par_r, tx_line_r, tx_tick;
  logic tx_load;

  assign tx_tick = (tx_cnt_r == baud_divisor);
  // Start a frame when idle or at the very end of the last stop bit.
  assign tx_load = tx_enable & tx_buf_full & ~consistency_error_flag
    & ((tx_st_r == LUF_IDLE) | (tx_st_r == LUF_STOP & tx_tick
      & (tx_bit_r != CNT_RST) == stop_length_select));

  // Holding register filled by a software write.
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_hold_r <= DATA_RST;
      tx_buf_full <= 1'b0;
    end else if (!tx_enable) begin
      tx_buf_full <= 1'b0;
    end else if (tx_data_write) begin
      tx_hold_r <= tx_data_reg;
      tx_buf_full <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full <= 1'b0;
    end
  end

  // Frame sequencer for the serial output.
  always_ff @(posedge clk) begin
    if (reset || !tx_enable) begin
      tx_st_r <= LUF_IDLE;
      tx_cnt_r <= BAUD_RST;
      tx_bit_r <= CNT_RST;
      tx_sh_r <= DATA_RST;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (tx_load) begin
      tx_st_r <= LUF_START;
      tx_cnt_r <= BAUD_RST;
      tx_bit_r <= CNT_RST;
      tx_sh_r <= reorder(tx_hold_r, msb_first, char_length_select);
      tx_par_r <= par_bit(tx_hold_r, parity_select, char_length_select,
        ext_on);
      tx_line_r <= 1'b0;
    end else if (tx_st_r != LUF_IDLE) begin
      tx_cnt_r <= tx_tick ? BAUD_RST : tx_cnt_r + 16'h0001;
      if (tx_tick) begin
        case (tx_st_r)
          LUF_START: begin
            tx_st_r <= LUF_DATA;
            tx_line_r <= tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[DATA_W-1:1]};
          end
          LUF_DATA: begin
            if (tx_bit_r == nbits - 4'h1) begin
              tx_bit_r <= CNT_RST;
              if (parity_select == PAR_NONE) begin
                tx_st_r <= LUF_STOP;
                tx_line_r <= 1'b1;
              end else begin
                tx_st_r <= LUF_PAR;
                tx_line_r <= tx_par_r;
              end
            end else begin
              tx_bit_r <= tx_bit_r + 4'h1;
              tx_line_r <= tx_sh_r[0];
              tx_sh_r <= {1'b0, tx_sh_r[DATA_W-1:1]};
            end
          end
          LUF_PAR: begin
            tx_st_r <= LUF_STOP;
            tx_line_r <= 1'b1;
          end
          LUF_STOP: begin
            if (!stop_length_select || tx_bit_r != CNT_RST) begin
              tx_st_r <= LUF_IDLE;
            end
            tx_bit_r <= tx_bit_r + 4'h1;
          end
          default: begin
            tx_st_r <= LUF_IDLE;
          end
        endcase
      end
    end
  end

  assign tx_busy_flag = (tx_st_r != LUF_IDLE);

  // Output pin register and transmit interrupt pulse.
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_out_pin <= 1'b1;
      tx_irq <= 1'b0;
    end else begin
      serial_out_pin <= tx_line_r ^ tx_polarity_invert;
      tx_irq <= tx_irq_timing_select
        ? (tx_enable & tx_st_r == LUF_STOP & tx_tick & ~tx_load
           & (!stop_length_select || tx_bit_r != CNT_RST))
        : tx_load;
    end
  end

  // Readback check: mid-bit sample of the input against the sent level.
  always_ff @(posedge clk) begin
    if (reset) begin
      consistency_error_flag <= 1'b0;
    end else if (consistency_check_enable && tx_busy_flag
                 && tx_cnt_r == half_div && rx_line != tx_line_r) begin
      consistency_error_flag <= 1'b1;
    end else if (consistency_error_clear) begin
      consistency_error_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // Receiver
  // ==========================================================================
  luf_state_type rx_st_r;
  logic [BAUD_W-1:0] rx_cnt_r;
  logic [CNT_W-1:0] rx_bit_r;
  logic [DATA_W-1:0] rx_sh_r;
  logic rx_perr_r, rx_unread_r, rx_tick, rx_fall, rx_end;
  logic [DATA_W-1:0] rx_word;

  assign rx_tick = (rx_cnt_r == baud_divisor);
  // Edge needs the previous sample high while enabled.
  assign rx_fall = rxd_r & ~rx_line;
  assign rx_end = rx_st_r == LUF_STOP & rx_tick;
  // Undo reception order; the character ends up right aligned.
  assign rx_word = reorder(rx_sh_r >> (4'h9 - nbits), msb_first,
    char_length_select);

  // Receive sequencer; sampling happens at each bit centre.
  always_ff @(posedge clk) begin
    if (reset || !rx_enable) begin
      rx_st_r <= LUF_IDLE;
      rx_cnt_r <= BAUD_RST;
      rx_bit_r <= CNT_RST;
      rx_sh_r <= DATA_RST;
      rx_perr_r <= 1'b0;
    end else begin
      rx_cnt_r <= (rx_tick || rx_st_r == LUF_IDLE) ? BAUD_RST
        : rx_cnt_r + 16'h0001;
      case (rx_st_r)
        LUF_IDLE: begin
          if (rx_fall) begin
            rx_st_r <= LUF_START;
            rx_bit_r <= CNT_RST;
            rx_perr_r <= 1'b0;
          end
        end
        LUF_START: begin
          if (rx_cnt_r == half_div) begin
            rx_cnt_r <= BAUD_RST;
            rx_st_r <= rx_line ? LUF_IDLE : LUF_DATA;
          end
        end
        LUF_DATA: begin
          if (rx_tick) begin
            rx_sh_r <= {rx_line, rx_sh_r[DATA_W-1:1]};
            if (rx_bit_r == nbits - 4'h1) begin
              rx_st_r <= (parity_select == PAR_NONE) ? LUF_STOP : LUF_PAR;
            end
            rx_bit_r <= rx_bit_r + 4'h1;
          end
        end
        LUF_PAR: begin
          if (rx_tick) begin
            rx_st_r <= LUF_STOP;
            rx_perr_r <= (rx_line != par_bit(rx_word, parity_select,
              char_length_select, ext_on));
          end
        end
        LUF_STOP: begin
          if (rx_tick) begin
            rx_st_r <= LUF_IDLE;
          end
        end
        default: begin
          rx_st_r <= LUF_IDLE;
        end
      endcase
    end
  end

  assign rx_busy_flag = (rx_st_r != LUF_IDLE);

  // Data transfer, error flags and receive interrupts at the stop bit.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_data_reg <= DATA_RST;
      rx_unread_r <= 1'b0;
      overrun_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      rx_done_irq <= 1'b0;
      status_irq <= 1'b0;
    end else begin
      rx_done_irq <= 1'b0;
      status_irq <= tx_busy_flag & consistency_check_enable
        & ~consistency_error_flag & tx_cnt_r == half_div
        & rx_line != tx_line_r;
      if (rx_data_read) begin
        rx_unread_r <= 1'b0;
      end
      if (overrun_clear) begin
        overrun_flag <= 1'b0;
      end
      if (rx_end) begin
        parity_error_flag <= rx_perr_r;
        framing_error_flag <= ~rx_line;
        if (rx_unread_r && !rx_data_read) begin
          overrun_flag <= 1'b1;
          status_irq <= 1'b1;
        end else begin
          rx_data_reg <= rx_word;
          rx_unread_r <= rx_perr_r | ~rx_line;
          if (rx_perr_r || !rx_line) begin
            status_irq <= 1'b1;
          end else begin
            rx_done_irq <= 1'b1;
          end
        end
      end
    end
  end

endmodule : luf_frame_txrx

// ### rtl/luf_pkg.sv
// Shared constants for the frame-level serial transmit and receive engine.
package luf_pkg;

  // ==========================================================================
  // Frame format encodings
  // ==========================================================================
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int DATA_W = 9;
  localparam int BAUD_W = 16;
  localparam int CNT_W = 4;
  localparam logic [DATA_W-1:0] DATA_RST = 9'h000;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

  // Line states.
  typedef enum logic [2:0] {
    LUF_IDLE, LUF_START, LUF_DATA, LUF_PAR, LUF_STOP
  } luf_state_type;

endpackage : luf_pkg

// ### test/luf_frame_txrx_assertions.sv
// Concurrent checks on the ports of the frame engine.
`timescale 1ns/1ps
module luf_frame_chk
  import luf_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_data_write,
  input wire logic tx_irq_timing_select,
  input wire logic tx_polarity_invert,
  input wire logic serial_out_pin,
  input wire logic tx_busy_flag,
  input wire logic rx_busy_flag,
  input wire logic tx_buf_full,
  input wire logic consistency_error_flag,
  input wire logic tx_irq,
  input wire logic rx_done_irq,
  input wire logic status_irq
);
  // ==========================================================================
  // Port relations
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic go;
  // A write that an idle, unblocked transmitter takes at once.
  assign go = tx_data_write && tx_enable && !tx_busy_flag && !tx_buf_full
              && !consistency_error_flag;
  reset_quiet_a: assert property (disable iff (1'b0) reset |=>
    !tx_busy_flag && !tx_irq && !status_irq) else $error("busy after reset");
  tx_start_a: assert property (go |-> ##2 tx_busy_flag && !tx_buf_full)
    else $error("write did not start a frame");
  load_irq_a: assert property (go && !tx_irq_timing_select |-> ##2 tx_irq)
    else $error("no transmit interrupt at load");
  start_level_a: assert property (go |-> ##3
    serial_out_pin == tx_polarity_invert) else $error("no start bit");
  tx_abort_a: assert property (!tx_enable |=> !tx_busy_flag)
    else $error("transmit not aborted");
  rx_abort_a: assert property (!rx_enable |=> !rx_busy_flag)
    else $error("receive not aborted");
  idle_level_a: assert property (!tx_busy_flag && $past(tx_enable) &&
    $stable(tx_polarity_invert) |-> serial_out_pin != tx_polarity_invert)
    else $error("wrong idle level");
  rx_irq_excl_a: assert property (!(rx_done_irq && status_irq))
    else $error("done and status together");
endmodule : luf_frame_chk

bind luf_frame_txrx luf_frame_chk u_chk (.clk(clk), .reset(reset),
  .tx_enable(tx_enable), .rx_enable(rx_enable), .tx_data_write(tx_data_write),
  .tx_irq_timing_select(tx_irq_timing_select),
  .tx_polarity_invert(tx_polarity_invert), .serial_out_pin(serial_out_pin),
  .tx_busy_flag(tx_busy_flag), .rx_busy_flag(rx_busy_flag),
  .tx_buf_full(tx_buf_full), .consistency_error_flag(consistency_error_flag),
  .tx_irq(tx_irq), .rx_done_irq(rx_done_irq), .status_irq(status_irq));

// ### test/luf_line_model.sv
// Far serial node that sends frames and can echo a corrupted line.
`timescale 1ns/1ps
module luf_line_model (
  input wire logic clk,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  logic lvl = 1'b1;
  logic echo_bad = 1'b0;
  // The line carries our own frame or a corrupted echo of the device.
  assign line_to_dut = echo_bad ? ~line_from_dut : lvl;
  // Drives each bit for n cycles, then parks the line at its idle level.
  task automatic send(input bit b[$], input int n, input logic inv);
    foreach (b[i]) begin
      lvl = b[i] ^ inv;
      repeat (n) @(negedge clk);
    end
    lvl = ~inv;
  endtask : send
endmodule : luf_line_model

// ### test/testbench.sv
// Self-checking bench of the frame transmit and receive engine.
`timescale 1ns/1ps
module testbench import luf_pkg::*;;
  localparam int N = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] baud_divisor = 16'h0003;
  logic tx_enable, rx_enable, char_length_select, stop_length_select;
  logic msb_first, expansion_bit_enable, tx_polarity_invert;
  logic rx_polarity_invert, tx_irq_timing_select, consistency_check_enable;
  logic consistency_error_clear, overrun_clear, tx_data_write, rx_data_read;
  logic [1:0] parity_select;
  logic [8:0] tx_data_reg, rx_data_reg;
  logic serial_in_pin, serial_out_pin, tx_busy_flag, rx_busy_flag;
  logic tx_buf_full, overrun_flag, parity_error_flag, framing_error_flag;
  logic consistency_error_flag, tx_irq, rx_done_irq, status_irq;
  logic seen_rx, seen_st;
  int err_total = 0;
  int cmp_count = 0;
  int tn = 0;
  bit eq[$];

  luf_frame_txrx dut (.clk(clk), .reset(reset), .baud_divisor(baud_divisor),
    .tx_enable(tx_enable), .rx_enable(rx_enable),
    .char_length_select(char_length_select),
    .stop_length_select(stop_length_select), .parity_select(parity_select),
    .msb_first(msb_first), .expansion_bit_enable(expansion_bit_enable),
    .tx_polarity_invert(tx_polarity_invert),
    .rx_polarity_invert(rx_polarity_invert),
    .tx_irq_timing_select(tx_irq_timing_select),
    .consistency_check_enable(consistency_check_enable),
    .consistency_error_clear(consistency_error_clear),
    .overrun_clear(overrun_clear), .tx_data_write(tx_data_write),
    .tx_data_reg(tx_data_reg), .rx_data_read(rx_data_read),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .rx_data_reg(rx_data_reg), .tx_busy_flag(tx_busy_flag),
    .rx_busy_flag(rx_busy_flag), .tx_buf_full(tx_buf_full),
    .overrun_flag(overrun_flag), .parity_error_flag(parity_error_flag),
    .framing_error_flag(framing_error_flag),
    .consistency_error_flag(consistency_error_flag), .tx_irq(tx_irq),
    .rx_done_irq(rx_done_irq), .status_irq(status_irq));
  luf_line_model m (.clk(clk), .line_from_dut(serial_out_pin),
    .line_to_dut(serial_in_pin));

  // Clock toggles every half period.
  always #10 clk = ~clk;

  // Ends the run with the counts and the verdict.
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // Compares a seen value with the expected one.
  task automatic chk(input logic [8:0] s, input logic [8:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask : chk

  // Waits for the interrupt or the line to reach a level, within a bound.
  task automatic wt(input bit irq, input logic v);
    int k;
    k = 0;
    while ((irq ? tx_irq : serial_out_pin) !== v) begin
      if (k++ == 2 * N) begin
        chk(irq ? tx_irq : serial_out_pin, v);
        end_sim;
      end
      @(negedge clk);
    end
  endtask : wt

  // Watches the receive interrupts for c cycles.
  task automatic watch(input int c);
    seen_rx = 1'b0;
    seen_st = 1'b0;
    repeat (c) begin
      @(negedge clk);
      seen_rx |= rx_done_irq;
      seen_st |= status_irq;
    end
  endtask : watch

  // Appends the line bits of one frame in the current format.
  task automatic mk(input logic [8:0] d, input bit stop2);
    int n;
    logic p;
    n = char_length_select ? 8 : 7;
    p = 1'b0;
    eq.push_back(1'b0);
    for (int i = 0; i < n; i++) begin
      eq.push_back(msb_first ? d[n-1-i] : d[i]);
      p ^= d[i];
    end
    if (char_length_select && expansion_bit_enable) begin
      eq.push_back(d[8]);
      p ^= d[8];
    end
    if (parity_select != PAR_NONE) begin
      eq.push_back(parity_select == PAR_ZERO ? 1'b0 :
        p ^ (parity_select == PAR_ODD));
    end
    eq.push_back(1'b1);
    if (stop2) eq.push_back(1'b1);
  endtask : mk

  // Writes one or two characters and checks every bit on the line.
  task automatic tx(input logic [8:0] d1, input logic [8:0] d2, input bit two);
    eq = {};
    mk(d1, stop_length_select);
    if (two) mk(d2, stop_length_select);
    tx_data_reg = d1;
    tx_data_write = 1'b1;
    @(negedge clk) tx_data_write = 1'b0;
    @(negedge clk);
    chk(tx_irq, !tx_irq_timing_select);
    wt(1'b0, tx_polarity_invert);
    if (two) begin
      tx_data_reg = d2;
      tx_data_write = 1'b1;
    end
    @(negedge clk) tx_data_write = 1'b0;
    foreach (eq[i]) begin
      chk(serial_out_pin ^ tx_polarity_invert, eq[i]);
      if (tx_irq_timing_select && i == eq.size() - 1) break;
      repeat (N) @(negedge clk);
    end
    if (tx_irq_timing_select) begin
      wt(1'b1, 1'b1);
      chk(tx_busy_flag, 1'b0);
    end
  endtask : tx

  // Sends a frame from the far node and checks what the receiver kept.
  // A nonzero bad counts back from the end: 1 breaks the stop bit, 2 parity.
  task automatic rx(input logic [8:0] d, input int bad, input logic [8:0] ed,
                    input bit st);
    eq = {};
    mk(d, 1'b0);
    if (bad > 0) eq[eq.size()-bad] ^= 1'b1;
    fork
      m.send(eq, N, rx_polarity_invert);
      watch(eq.size() * N + 2 * N);
    join
    chk(rx_data_reg, ed);
    chk(seen_rx, !st);
    chk(seen_st, st);
    chk(framing_error_flag, bad == 1);
  endtask : rx

  // Main sequence of tests.
  initial begin
    tx_data_reg = 9'h000;
    {tx_enable, rx_enable, char_length_select, stop_length_select,
     parity_select, msb_first, expansion_bit_enable, tx_polarity_invert,
     rx_polarity_invert, tx_irq_timing_select, consistency_check_enable,
     consistency_error_clear, overrun_clear, tx_data_write,
     rx_data_read} = '0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    m.lvl = 1'b0;
    repeat (2) @(negedge clk);
    rx_enable = 1'b1;
    repeat (3 * N) @(negedge clk);
    m.lvl = 1'b1;
    @(negedge clk) m.lvl = 1'b0;
    @(negedge clk) m.lvl = 1'b1;
    watch(4 * N);
    chk(rx_busy_flag | seen_rx | seen_st, 1'b0);
    $display("test 1 ended");
    tx_enable = 1'b1;
    {char_length_select, stop_length_select, parity_select, msb_first,
     expansion_bit_enable, tx_polarity_invert, tx_irq_timing_select} = 8'hB1;
    tx(9'h055, 9'h000, 1'b0);
    {char_length_select, stop_length_select, parity_select, msb_first,
     expansion_bit_enable, tx_polarity_invert, tx_irq_timing_select} = 8'h6B;
    tx(9'h036, 9'h000, 1'b0);
    $display("test 2 ended");
    for (int p = 0; p < 4; p++) begin
      {char_length_select, stop_length_select, parity_select, msb_first,
       expansion_bit_enable, tx_polarity_invert, tx_irq_timing_select} =
        {2'b10, p[1:0], 4'h4};
      tx(9'h155, 9'h087, 1'b1);
    end
    $display("test 3 ended");
    rx_enable = 1'b0;
    rx_polarity_invert = 1'b1;
    m.lvl = 1'b0;
    {parity_select, msb_first} = {PAR_EVEN, 1'b1};
    @(negedge clk) rx_enable = 1'b1;
    rx(9'h0A5, 1'b0, 9'h0A5, 1'b0);
    rx(9'h05A, 2, 9'h05A, 1'b1);
    chk(parity_error_flag, 1'b1);
    rx(9'h033, 1'b0, 9'h05A, 1'b1);
    chk(overrun_flag, 1'b1);
    {rx_data_read, overrun_clear} = 2'b11;
    @(negedge clk) {rx_data_read, overrun_clear} = 2'b00;
    chk(overrun_flag, 1'b0);
    rx(9'h0C3, 1'b0, 9'h0C3, 1'b0);
    rx(9'h04B, 1, 9'h04B, 1'b1);
    $display("test 4 ended");
    {rx_enable, rx_polarity_invert, consistency_check_enable} = 3'b001;
    m.echo_bad = 1'b1;
    tx_data_reg = 9'h011;
    tx_data_write = 1'b1;
    @(negedge clk) tx_data_write = 1'b0;
    watch(14 * N);
    chk({consistency_error_flag, seen_st}, 2'b11);
    tx_data_write = 1'b1;
    @(negedge clk) tx_data_write = 1'b0;
    repeat (3) @(negedge clk);
    chk(tx_busy_flag, 1'b0);
    {tx_enable, consistency_error_clear, m.echo_bad} = 3'b010;
    @(negedge clk) consistency_error_clear = 1'b0;
    chk({consistency_error_flag, tx_busy_flag}, 2'b00);
    $display("test 5 ended");
    end_sim;
  end
endmodule : testbench
